// [core/mdd_device.sv]
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module mdd_device
    import mdd_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    mdd_link_if.device LINK,
    input wire logic I_SEC_LOCKED,
    input wire logic I_SPINUP_DIS,
    input wire logic I_VERIFY_OK,
    input wire logic [7:0] I_DIAG_CODE,
    output logic O_FW_ACTIVATE,
    output logic O_SPIN_DOWN,
    output logic O_IMG_DISCARD,
    output logic [15:0] O_IMG_WORD,
    output logic O_IMG_WE,
    output logic [15:0] O_IMG_SEC
);
    // ========================================
    // state machine, gray in declaration order, not along download path
    typedef enum logic [2:0] {
        MDD_S_IDLE = 3'b000,
        MDD_S_XFER = 3'b001,
        MDD_S_CHECK = 3'b011,
        MDD_S_DONE = 3'b010,
        MDD_S_DIAG = 3'b110
    } mdd_state_t;

    mdd_state_t st_r, st_nxt;
    logic [7:0] mode_r, mode_nxt, cnt_lo_r, cnt_lo_nxt;
    logic [7:0] cnt_hi_r, cnt_hi_nxt, ofs_lo_r, ofs_lo_nxt;
    logic [7:0] drv_r, drv_nxt, err_r, err_nxt, stat_r, stat_nxt;
    logic [15:0] left_r, left_nxt, sec_r, sec_nxt;
    logic [15:0] expect_r, expect_nxt;
    logic [7:0] word_r, word_nxt, ofs_hi_r, ofs_hi_nxt;
    logic seg_open_r, seg_open_nxt, reload_r, reload_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic req_r, req_nxt, irq_r, irq_nxt;
    logic act_r, act_nxt, spin_r, spin_nxt, disc_r, disc_nxt;
    logic [15:0] wd_r, wd_nxt;
    logic we_r, we_nxt;
    logic [15:0] cnt_w, ofs_w;

    // 16-bit quantities assembled from byte registers
    assign cnt_w = {cnt_hi_r, cnt_lo_r};
    assign ofs_w = {ofs_hi_r, ofs_lo_r};

    // ========================================
    // next state and register values
    always_comb begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        cnt_lo_nxt = cnt_lo_r;
        cnt_hi_nxt = cnt_hi_r;
        ofs_lo_nxt = ofs_lo_r;
        ofs_hi_nxt = ofs_hi_r;
        drv_nxt = drv_r;
        err_nxt = err_r;
        stat_nxt = stat_r;
        left_nxt = left_r;
        sec_nxt = sec_r;
        expect_nxt = expect_r;
        word_nxt = word_r;
        seg_open_nxt = seg_open_r;
        reload_nxt = reload_r;
        req_nxt = 1'b0;
        irq_nxt = irq_r;
        act_nxt = 1'b0;
        spin_nxt = spin_r;
        disc_nxt = 1'b0;
        wd_nxt = wd_r;
        we_nxt = 1'b0;
        rdata_nxt = rdata_r;
        // register reads; status read drops the interrupt
        if (LINK.tf_re) begin
            unique case (LINK.tf_addr)
                MDD_REG_ERR: rdata_nxt = err_r;
                MDD_REG_CNT_LO: rdata_nxt = cnt_lo_r;
                MDD_REG_CNT_HI: rdata_nxt = cnt_hi_r;
                MDD_REG_OFS_LO: rdata_nxt = ofs_lo_r;
                MDD_REG_OFS_HI: rdata_nxt = ofs_hi_r;
                MDD_REG_DRIVE: rdata_nxt = drv_r;
                MDD_REG_STAT: begin
                    rdata_nxt = stat_r;
                    irq_nxt = 1'b0;
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
        // parameter writes while not busy
        if (LINK.tf_we && !stat_r[MDD_ST_BSY]) begin
            unique case (LINK.tf_addr)
                MDD_REG_MODE: mode_nxt = LINK.tf_wdata;
                MDD_REG_CNT_LO: cnt_lo_nxt = LINK.tf_wdata;
                MDD_REG_CNT_HI: cnt_hi_nxt = LINK.tf_wdata;
                MDD_REG_OFS_LO: ofs_lo_nxt = LINK.tf_wdata;
                MDD_REG_OFS_HI: ofs_hi_nxt = LINK.tf_wdata;
                MDD_REG_DRIVE: drv_nxt = LINK.tf_wdata;
                default: ;
            endcase
        end
        unique case (st_r)
            MDD_S_IDLE: begin
                if (LINK.tf_we && LINK.tf_addr == MDD_REG_CMD) begin
                    err_nxt = 8'h00;
                    irq_nxt = 1'b0;
                    stat_nxt[MDD_ST_BSY] = 1'b1;
                    stat_nxt[MDD_ST_ERR] = 1'b0;
                    if (LINK.tf_wdata == MDD_CMD_DL_DMA) begin
                        st_nxt = MDD_S_CHECK;
                    end else if (LINK.tf_wdata == MDD_CMD_DIAG) begin
                        st_nxt = MDD_S_DIAG;
                        word_nxt = MDD_DIAG_CYC;
                        seg_open_nxt = 1'b0;
                        disc_nxt = seg_open_r;
                    end else begin
                        st_nxt = MDD_S_DONE;
                        seg_open_nxt = 1'b0;
                        disc_nxt = seg_open_r;
                    end
                end
            end
            MDD_S_CHECK: begin
                st_nxt = MDD_S_XFER;
                left_nxt = cnt_w;
                word_nxt = 8'h00;
                reload_nxt = 1'b0;
                if (I_SEC_LOCKED || (mode_r != MDD_MODE_SEG &&
                        mode_r != MDD_MODE_FULL)) begin
                    err_nxt[MDD_ERR_ABT] = 1'b1;
                    st_nxt = MDD_S_DONE;
                end else if (mode_r == MDD_MODE_SEG) begin
                    // sequence check; new image only at offset zero
                    if (ofs_w != (seg_open_r ? expect_r : 16'h0000)) begin
                        err_nxt[MDD_ERR_ABT] = 1'b1;
                        seg_open_nxt = 1'b0;
                        disc_nxt = 1'b1;
                        st_nxt = MDD_S_DONE;
                    end else begin
                        sec_nxt = ofs_w;
                        expect_nxt = ofs_w + cnt_w;
                        seg_open_nxt = 1'b1;
                    end
                end else begin
                    sec_nxt = 16'h0000; // offset ignored
                    disc_nxt = seg_open_r;
                    seg_open_nxt = 1'b0;
                end
                // zero count: nothing moves, a segment command ends it
                if (cnt_w == 16'h0000 && st_nxt == MDD_S_XFER) begin
                    st_nxt = MDD_S_DONE;
                    if (mode_r == MDD_MODE_SEG) begin
                        seg_open_nxt = 1'b0;
                        reload_nxt = 1'b1;
                    end
                end
            end
            MDD_S_XFER: begin
                req_nxt = 1'b1;
                // whole sectors of 256 words assumed from host
                if (LINK.dma_ack && req_r) begin
                    wd_nxt = LINK.dma_data;
                    we_nxt = 1'b1;
                    word_nxt = word_r + 8'h01;
                    // index moves with the first word of the next sector
                    if (word_r == 8'h00 && left_r != cnt_w) begin
                        sec_nxt = sec_r + 16'h0001;
                    end
                    if (word_r == MDD_WORD_IDX_MAX) begin
                        left_nxt = left_r - 16'h0001;
                        if (left_r == 16'h0001) begin
                            req_nxt = 1'b0;
                            st_nxt = MDD_S_DONE;
                            reload_nxt = (mode_r == MDD_MODE_FULL);
                        end
                    end
                end
            end
            MDD_S_DIAG: begin
                word_nxt = word_r - 8'h01;
                if (word_r == 8'h01) begin
                    err_nxt = I_DIAG_CODE;
                    // a code, not flags, so error summary stays low
                    stat_nxt[MDD_ST_BSY] = 1'b0;
                    irq_nxt = 1'b1;
                    st_nxt = MDD_S_IDLE;
                end
            end
            MDD_S_DONE: begin
                // verify and activate; failure only when reload asked
                if (reload_r) begin
                    if (I_VERIFY_OK) begin
                        act_nxt = 1'b1;
                        spin_nxt = I_SPINUP_DIS;
                    end else begin
                        err_nxt[MDD_ERR_UNC] = 1'b1;
                    end
                    reload_nxt = 1'b0;
                end else begin
                    stat_nxt[MDD_ST_BSY] = 1'b0;
                    stat_nxt[MDD_ST_ERR] =
                        err_r[MDD_ERR_ABT] | err_r[MDD_ERR_UNC];
                    irq_nxt = 1'b1;
                    st_nxt = MDD_S_IDLE;
                end
            end
            default: st_nxt = MDD_S_IDLE;
        endcase
        // soft reset abandons partial image before resetting
        if (LINK.soft_reset) begin
            disc_nxt = seg_open_r;
            seg_open_nxt = 1'b0;
            st_nxt = MDD_S_IDLE;
            stat_nxt = MDD_STAT_RST;
            err_nxt = MDD_ERR_RST;
            req_nxt = 1'b0;
            irq_nxt = 1'b0;
            reload_nxt = 1'b0;
        end
    end

    // ========================================
    // registers; hardware reset closes any image without a discard pulse
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            st_r <= MDD_S_IDLE;
            mode_r <= 8'h00;
            cnt_lo_r <= 8'h00;
            cnt_hi_r <= 8'h00;
            ofs_lo_r <= 8'h00;
            ofs_hi_r <= 8'h00;
            drv_r <= 8'h00;
            err_r <= MDD_ERR_RST;
            stat_r <= MDD_STAT_RST;
            left_r <= 16'h0000;
            sec_r <= 16'h0000;
            expect_r <= 16'h0000;
            word_r <= 8'h00;
            seg_open_r <= 1'b0;
            reload_r <= 1'b0;
            rdata_r <= 8'h00;
            req_r <= 1'b0;
            irq_r <= 1'b0;
            act_r <= 1'b0;
            spin_r <= 1'b0;
            disc_r <= 1'b0;
            wd_r <= 16'h0000;
            we_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            cnt_lo_r <= cnt_lo_nxt;
            cnt_hi_r <= cnt_hi_nxt;
            ofs_lo_r <= ofs_lo_nxt;
            ofs_hi_r <= ofs_hi_nxt;
            drv_r <= drv_nxt;
            err_r <= err_nxt;
            stat_r <= stat_nxt;
            left_r <= left_nxt;
            sec_r <= sec_nxt;
            expect_r <= expect_nxt;
            word_r <= word_nxt;
            seg_open_r <= seg_open_nxt;
            reload_r <= reload_nxt;
            rdata_r <= rdata_nxt;
            req_r <= req_nxt;
            irq_r <= irq_nxt;
            act_r <= act_nxt;
            spin_r <= spin_nxt;
            disc_r <= disc_nxt;
            wd_r <= wd_nxt;
            we_r <= we_nxt;
        end
    end

    // outputs straight from flops
    assign LINK.tf_rdata = rdata_r;
    assign LINK.dma_req = req_r;
    assign LINK.intrq = irq_r;
    assign O_FW_ACTIVATE = act_r;
    assign O_SPIN_DOWN = spin_r;
    assign O_IMG_DISCARD = disc_r;
    assign O_IMG_WORD = wd_r;
    assign O_IMG_WE = we_r;
    assign O_IMG_SEC = sec_r;
endmodule : mdd_device

// [core/mdd_host.sv]
`timescale 1ns/100ps
// controller end: software drives taskfile through a register port
module mdd_host
    import mdd_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    mdd_link_if.host LINK,
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WE,
    input wire logic I_RE,
    output logic [7:0] O_RDATA,
    output logic O_IRQ
);
    logic tf_we_r, tf_we_nxt, tf_re_r, tf_re_nxt;
    logic [3:0] tf_addr_r, tf_addr_nxt;
    logic [7:0] tf_wd_r, tf_wd_nxt, rd_r, rd_nxt;
    logic [2:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic [15:0] word_r, word_nxt;
    logic word_ok_r, word_ok_nxt, srst_r, srst_nxt, ack_r, ack_nxt;
    logic irq_r, irq_nxt, hi_r, hi_nxt, intrq_d_r, intrq_d_nxt;
    logic [7:0] done_r, done_nxt;

    // ========================================
    // software port, taskfile forwarding and dma word pacing
    always_comb begin
        tf_we_nxt = 1'b0;
        tf_re_nxt = 1'b0;
        tf_addr_nxt = tf_addr_r;
        tf_wd_nxt = tf_wd_r;
        rd_nxt = 8'h00;
        ist_nxt = ist_r;
        imask_nxt = imask_r;
        word_nxt = word_r;
        word_ok_nxt = word_ok_r;
        srst_nxt = 1'b0;
        ack_nxt = 1'b0;
        hi_nxt = hi_r;
        intrq_d_nxt = LINK.intrq;
        done_nxt = done_r;
        // interrupt clear by writing one, set wins over clear
        if (I_WE && I_ADDR == MDD_H_IRQ_STAT) begin
            ist_nxt = ist_r & ~I_WDATA[2:0];
        end
        if (I_WE && I_ADDR < MDD_H_IRQ_STAT) begin
            tf_we_nxt = 1'b1;
            tf_addr_nxt = I_ADDR;
            tf_wd_nxt = I_WDATA;
        end
        if (I_WE && I_ADDR == MDD_H_IRQ_MASK) begin
            imask_nxt = I_WDATA[2:0];
        end
        if (I_WE && I_ADDR == MDD_H_WDATA) begin
            // low byte then high byte shifts into the dma word
            word_nxt = {I_WDATA, word_r[15:8]};
            // the word is marked ready only once its high byte is written
            word_ok_nxt = hi_r;
            hi_nxt = !hi_r;
        end
        if (I_WE && I_ADDR == MDD_H_CTRL) begin
            srst_nxt = I_WDATA[0];
        end
        // taskfile reads take two cycles, so data come from the previous device read
        if (I_RE) begin
            unique case (I_ADDR)
                MDD_H_IRQ_STAT: rd_nxt = {5'h00, ist_r};
                MDD_H_IRQ_MASK: rd_nxt = {5'h00, imask_r};
                MDD_H_CTRL: rd_nxt = {7'h00, word_ok_r};
                MDD_H_DONE_CNT: rd_nxt = done_r;
                default: begin
                    if (I_ADDR < MDD_H_IRQ_STAT) begin
                        tf_re_nxt = 1'b1;
                        tf_addr_nxt = I_ADDR;
                        rd_nxt = LINK.tf_rdata;
                    end
                end
            endcase
        end
        // one word per request and a fresh word each time
        if (LINK.dma_req && word_ok_r && !ack_r) begin
            ack_nxt = 1'b1;
            word_ok_nxt = 1'b0;
        end
        if (LINK.dma_req && !word_ok_r) begin
            ist_nxt[MDD_IRQ_WREQ] = 1'b1;
        end
        if (LINK.intrq && !intrq_d_r) begin
            ist_nxt[MDD_IRQ_DONE] = 1'b1;
            done_nxt = done_r + 8'h01;
        end
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            tf_we_r <= 1'b0;
            tf_re_r <= 1'b0;
            tf_addr_r <= 4'h0;
            tf_wd_r <= 8'h00;
            rd_r <= 8'h00;
            ist_r <= 3'h0;
            imask_r <= 3'h0;
            word_r <= 16'h0000;
            word_ok_r <= 1'b0;
            srst_r <= 1'b0;
            ack_r <= 1'b0;
            irq_r <= 1'b0;
            hi_r <= 1'b0;
            intrq_d_r <= 1'b0;
            done_r <= 8'h00;
        end else begin
            tf_we_r <= tf_we_nxt;
            tf_re_r <= tf_re_nxt;
            tf_addr_r <= tf_addr_nxt;
            tf_wd_r <= tf_wd_nxt;
            rd_r <= rd_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            word_r <= word_nxt;
            word_ok_r <= word_ok_nxt;
            srst_r <= srst_nxt;
            ack_r <= ack_nxt;
            irq_r <= irq_nxt;
            hi_r <= hi_nxt;
            intrq_d_r <= intrq_d_nxt;
            done_r <= done_nxt;
        end
    end

    assign LINK.tf_we = tf_we_r;
    assign LINK.tf_re = tf_re_r;
    assign LINK.tf_addr = tf_addr_r;
    assign LINK.tf_wdata = tf_wd_r;
    assign LINK.soft_reset = srst_r;
    assign LINK.dma_ack = ack_r;
    assign LINK.dma_data = word_r;
    assign O_RDATA = rd_r;
    assign O_IRQ = irq_r;
endmodule : mdd_host

// [core/mdd_link_if.sv]
`timescale 1ns/100ps
// taskfile and dma word link between controller and device
interface mdd_link_if;
    logic tf_we;
    logic tf_re;
    logic [3:0] tf_addr;
    logic [7:0] tf_wdata;
    logic [7:0] tf_rdata;
    logic soft_reset;
    logic dma_req;
    logic dma_ack;
    logic [15:0] dma_data;
    logic intrq;

    modport device (
        input tf_we, tf_re, tf_addr, tf_wdata, soft_reset, dma_ack,
        dma_data,
        output tf_rdata, dma_req, intrq
    );
    modport host (
        output tf_we, tf_re, tf_addr, tf_wdata, soft_reset, dma_ack,
        dma_data,
        input tf_rdata, dma_req, intrq
    );
endinterface : mdd_link_if

// [core/mdd_pkg.sv]
package mdd_pkg;
    // ========================================
    // taskfile register indices on the link
    localparam logic [3:0] MDD_REG_DATA = 4'h0;
    localparam logic [3:0] MDD_REG_MODE = 4'h1;
    localparam logic [3:0] MDD_REG_CNT_LO = 4'h2;
    localparam logic [3:0] MDD_REG_CNT_HI = 4'h3;
    localparam logic [3:0] MDD_REG_OFS_LO = 4'h4;
    localparam logic [3:0] MDD_REG_OFS_HI = 4'h5;
    localparam logic [3:0] MDD_REG_DRIVE = 4'h6;
    localparam logic [3:0] MDD_REG_CMD = 4'h7;
    // reads of index 1 and 7 return error and status
    localparam logic [3:0] MDD_REG_ERR = 4'h1;
    localparam logic [3:0] MDD_REG_STAT = 4'h7;
    // ========================================
    // command codes and download modes
    localparam logic [7:0] MDD_CMD_DL_DMA = 8'h93;
    localparam logic [7:0] MDD_CMD_DIAG = 8'h90;
    localparam logic [7:0] MDD_MODE_SEG = 8'h03;
    localparam logic [7:0] MDD_MODE_FULL = 8'h07;
    // ========================================
    // error and status bit positions
    localparam int MDD_ERR_UNC = 6;
    localparam int MDD_ERR_ABT = 2;
    localparam int MDD_ST_BSY = 7;
    localparam int MDD_ST_RDY = 6;
    localparam int MDD_ST_DSC = 4;
    localparam int MDD_ST_IDX = 1;
    localparam int MDD_ST_ERR = 0;
    localparam logic [7:0] MDD_STAT_RST = 8'h50;
    localparam logic [7:0] MDD_ERR_RST = 8'h01;
    // ========================================
    // sector geometry: 512 bytes as 256 16-bit words
    localparam logic [8:0] MDD_WORDS_PER_SEC = 9'h100;
    localparam logic [7:0] MDD_WORD_IDX_MAX = 8'hff;
    // arbitrary default diagnostic code, no meaning implied
    localparam logic [7:0] MDD_DIAG_PASS = 8'h01;
    // diagnostic run time in cycles
    localparam logic [7:0] MDD_DIAG_CYC = 8'h10;
    // ========================================
    // controller register offsets on the software port
    localparam logic [3:0] MDD_H_TF_BASE = 4'h0;
    localparam logic [3:0] MDD_H_IRQ_STAT = 4'h8;
    localparam logic [3:0] MDD_H_IRQ_MASK = 4'h9;
    localparam logic [3:0] MDD_H_WDATA = 4'ha;
    localparam logic [3:0] MDD_H_CTRL = 4'hb;
    localparam logic [3:0] MDD_H_DONE_CNT = 4'hc;
    // interrupt status bits
    localparam int MDD_IRQ_DONE = 0;
    localparam int MDD_IRQ_ERR = 1;
    localparam int MDD_IRQ_WREQ = 2;
endpackage : mdd_pkg

// [tb/mdd_bench.sv]
`timescale 1ns/100ps
module mdd_bench
    import mdd_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0;
    logic lock = 1'b0, spd = 1'b0, vok = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00, dcode = 8'h00, rdata;
    logic fw, spin, disc, img_we, irq;
    logic [15:0] img_word, img_sec, exp_base;
    logic [15:0] exp_q[$];
    logic [7:0] bad[3] = '{8'h00, 8'h05, 8'hff};
    int bad_count, checks, wcnt, n_fw, n_disc, nd, seed;

    mdd_link_if lk();
    mdd_device u_mdd_device (.I_CLK_SYS(clk), .I_RST(rst), .LINK(lk),
        .I_SEC_LOCKED(lock), .I_SPINUP_DIS(spd), .I_VERIFY_OK(vok),
        .I_DIAG_CODE(dcode), .O_FW_ACTIVATE(fw), .O_SPIN_DOWN(spin),
        .O_IMG_DISCARD(disc), .O_IMG_WORD(img_word), .O_IMG_WE(img_we),
        .O_IMG_SEC(img_sec));
    mdd_host u_mdd_host (.I_CLK_SYS(clk), .I_RST(rst), .LINK(lk),
        .I_ADDR(addr), .I_WDATA(wd), .I_WE(we), .I_RE(re), .O_RDATA(rdata),
        .O_IRQ(irq));
    mdd_props u_mdd_props (.I_CLK_SYS(clk), .I_RST(rst), .tf_we(lk.tf_we),
        .tf_re(lk.tf_re), .tf_addr(lk.tf_addr), .tf_wdata(lk.tf_wdata),
        .soft_reset(lk.soft_reset), .dma_req(lk.dma_req),
        .dma_ack(lk.dma_ack), .intrq(lk.intrq));

    initial forever #5 clk = ~clk;

    // ========================================
    // checking and bus tasks
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task final_report;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task hang;
        bad_count++;
        final_report();
    endtask : hang
    // one idle edge between strobes keeps each strobe a clean pulse
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd
    // taskfile reads come back one read late, so read twice
    task tfr(input logic [3:0] a, output logic [7:0] d);
        rd(a, d);
        rd(a, d);
    endtask : tfr
    task wait_we;
        int k;
        k = 0;
        @(negedge clk);
        while (img_we !== 1'b1 && k < 64) begin
            @(negedge clk);
            k++;
        end
        if (k >= 64) hang();
    endtask : wait_we
    task wait_idle;
        logic [7:0] s;
        int k;
        s = 8'h80;
        k = 0;
        while (s[MDD_ST_BSY] !== 1'b0 && k < 300) begin
            tfr(MDD_REG_STAT, s);
            k++;
        end
        if (k >= 300) hang();
    endtask : wait_idle
    // issue one command, stream its words, check the ending
    task dl(input logic [7:0] m, input logic [15:0] n, o,
            input logic [7:0] c, ee);
        logic [7:0] v;
        logic [15:0] d;
        wr(MDD_REG_MODE, m);
        wr(MDD_REG_CNT_LO, n[7:0]);
        wr(MDD_REG_CNT_HI, n[15:8]);
        wr(MDD_REG_OFS_LO, o[7:0]);
        wr(MDD_REG_OFS_HI, o[15:8]);
        exp_base = (m == MDD_MODE_SEG) ? o : 16'h0000;
        wcnt = 0;
        wr(MDD_REG_CMD, c);
        for (int i = 0; i < ((!ee[MDD_ERR_ABT] && c == MDD_CMD_DL_DMA) ?
                n * 256 : 0); i++) begin
            d = 16'($random(seed));
            exp_q.push_back(d);
            wr(MDD_H_WDATA, d[7:0]);
            wr(MDD_H_WDATA, d[15:8]);
            wait_we();
        end
        wait_idle();
        if (c == MDD_CMD_DL_DMA) begin
            tfr(MDD_REG_ERR, v);
            chk(16'(v & 8'h44), 16'(ee));
        end
        tfr(MDD_REG_STAT, v);
        chk(16'(v & 8'h81), {15'h0, ee != 8'h00});
    endtask : dl

    // ========================================
    // reference model of the image store
    always @(posedge clk) begin
        if (fw === 1'b1) n_fw++;
        if (disc === 1'b1) n_disc++;
        if (img_we === 1'b1) begin
            if (exp_q.size() == 0) chk(16'h1, 16'h0);
            else chk(img_word, exp_q.pop_front());
            chk(img_sec, exp_base + 16'(wcnt / 256));
            wcnt++;
        end
    end

    // ========================================
    // main sequence
    initial begin
        logic [7:0] v;
        logic ia;
        seed = 32'h43a7;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tfr(MDD_REG_STAT, v);
        chk(16'(v), 16'(MDD_STAT_RST));
        tfr(MDD_REG_ERR, v);
        chk(16'(v), 16'(MDD_ERR_RST));
        // full image; the offset must be ignored here
        dl(MDD_MODE_FULL, 16'h1, 16'h5, MDD_CMD_DL_DMA, 8'h00);
        chk(16'(n_fw), 16'h1);
        chk(16'(spin), 16'h0);
        // interrupt raised, hidden under mask 0, seen under mask 7, then cleared
        rd(MDD_H_IRQ_STAT, v);
        chk(16'(v[MDD_IRQ_DONE]), 16'h1);
        wr(MDD_H_IRQ_MASK, 8'h00);
        @(posedge clk);
        @(negedge clk);
        ia = irq;
        wr(MDD_H_IRQ_MASK, 8'h07);
        @(posedge clk);
        @(negedge clk);
        chk(16'(ia ^ irq), 16'h1);
        wr(MDD_H_IRQ_STAT, 8'h07);
        rd(MDD_H_IRQ_STAT, v);
        chk(16'(v[2:0]), 16'h0);
        chk(16'(irq), 16'h0);
        // segmented image, the zero count closes it
        dl(MDD_MODE_SEG, 16'h1, 16'h0, MDD_CMD_DL_DMA, 8'h00);
        dl(MDD_MODE_SEG, 16'h1, 16'h1, MDD_CMD_DL_DMA, 8'h00);
        dl(MDD_MODE_SEG, 16'h0, 16'h2, MDD_CMD_DL_DMA, 8'h00);
        chk(16'(n_fw), 16'h2);
        // failed reload, then a good one with spin-up disabled
        @(posedge clk);
        spd <= 1'b1;
        vok <= 1'b0;
        dl(MDD_MODE_FULL, 16'h1, 16'h0, MDD_CMD_DL_DMA, 8'h40);
        chk(16'(n_fw), 16'h2);
        @(posedge clk);
        vok <= 1'b1;
        dl(MDD_MODE_FULL, 16'h1, 16'h0, MDD_CMD_DL_DMA, 8'h00);
        chk(16'(spin), 16'h1);
        foreach (bad[i]) dl(bad[i], 16'h1, 16'h0, MDD_CMD_DL_DMA, 8'h04);
        @(posedge clk);
        lock <= 1'b1;
        dl(MDD_MODE_FULL, 16'h1, 16'h0, MDD_CMD_DL_DMA, 8'h04);
        @(posedge clk);
        lock <= 1'b0;
        // offset gap, then a first segment not at zero
        dl(MDD_MODE_SEG, 16'h1, 16'h0, MDD_CMD_DL_DMA, 8'h00);
        nd = n_disc;
        dl(MDD_MODE_SEG, 16'h1, 16'h3, MDD_CMD_DL_DMA, 8'h04);
        chk(16'(n_disc - nd), 16'h1);
        dl(MDD_MODE_SEG, 16'h1, 16'h1, MDD_CMD_DL_DMA, 8'h04);
        // diagnostic in the middle of a segmented image
        dl(MDD_MODE_SEG, 16'h1, 16'h0, MDD_CMD_DL_DMA, 8'h00);
        nd = n_disc;
        @(posedge clk);
        dcode <= 8'($random(seed));
        dl(8'h00, 16'h0, 16'h0, MDD_CMD_DIAG, 8'h00);
        tfr(MDD_REG_ERR, v);
        chk(16'(v), 16'(dcode));
        chk(16'(n_disc - nd), 16'h1);
        // soft reset in the middle of a segmented image
        dl(MDD_MODE_SEG, 16'h1, 16'h0, MDD_CMD_DL_DMA, 8'h00);
        nd = n_disc;
        wr(MDD_H_CTRL, 8'h01);
        wr(MDD_H_CTRL, 8'h00);
        repeat (4) @(posedge clk);
        chk(16'(n_disc - nd), 16'h1);
        tfr(MDD_REG_STAT, v);
        chk(16'(v), 16'(MDD_STAT_RST));
        final_report();
    end
endmodule : mdd_bench

// [tb/mdd_props.sv]
`timescale 1ns/100ps
module mdd_props
    import mdd_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic tf_we,
    input wire logic tf_re,
    input wire logic [3:0] tf_addr,
    input wire logic [7:0] tf_wdata,
    input wire logic soft_reset,
    input wire logic dma_req,
    input wire logic dma_ack,
    input wire logic intrq
);
    // ========================================
    // shadow of the taskfile as seen on the link
    logic [7:0] mode_r, cmd_r;
    logic [15:0] cnt_r;
    logic [23:0] acks_r;

    // ack count restarts with every command write
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            mode_r <= 8'h00;
            cmd_r <= 8'h00;
            cnt_r <= 16'h0000;
            acks_r <= 24'h000000;
        end else begin
            if (tf_we && tf_addr == MDD_REG_MODE) mode_r <= tf_wdata;
            if (tf_we && tf_addr == MDD_REG_CNT_LO) cnt_r[7:0] <= tf_wdata;
            if (tf_we && tf_addr == MDD_REG_CNT_HI) cnt_r[15:8] <= tf_wdata;
            if (tf_we && tf_addr == MDD_REG_CMD) begin
                cmd_r <= tf_wdata;
                acks_r <= 24'h000000;
            end else if (dma_req && dma_ack) begin
                acks_r <= acks_r + 24'h000001;
            end
        end
    end

    // ========================================
    // properties
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    sequence s_dl_cmd;
        tf_we && tf_addr == MDD_REG_CMD && tf_wdata == MDD_CMD_DL_DMA;
    endsequence
    sequence s_diag_cmd;
        tf_we && tf_addr == MDD_REG_CMD && tf_wdata == MDD_CMD_DIAG;
    endsequence

    a_req_in_dl: assert property (dma_req |-> cmd_r == MDD_CMD_DL_DMA)
        else $error("dma request outside a download");
    a_mode_bad: assert property ((s_dl_cmd ##0 (mode_r != MDD_MODE_SEG
        && mode_r != MDD_MODE_FULL)) |=> !dma_req [*8])
        else $error("reserved mode still moved data");
    a_zero_cnt: assert property ((s_dl_cmd ##0 cnt_r == 16'h0000)
        |=> !dma_req [*8])
        else $error("zero count still moved data");
    a_zero_done: assert property ((s_dl_cmd ##0 cnt_r == 16'h0000)
        |-> ##[2:30] intrq)
        else $error("zero count command did not complete");
    a_cnt_match: assert property (($rose(intrq) && cmd_r == MDD_CMD_DL_DMA)
        |-> (acks_r == 24'h0 || acks_r == {cnt_r, 8'h00}))
        else $error("word count differs from block count");
    a_ack_with_req: assert property (dma_ack |-> dma_req)
        else $error("word handed over without request");
    a_rst_drops: assert property (soft_reset |-> ##[1:2] !dma_req)
        else $error("transfer survives soft reset");
    a_diag_irq: assert property (s_diag_cmd
        |-> (!dma_req) throughout (##[1:40] intrq))
        else $error("diagnostic did not complete");
    a_stat_clr: assert property ((tf_re && tf_addr == MDD_REG_STAT && intrq)
        |-> ##[1:2] !intrq)
        else $error("status read left interrupt pending");
endmodule : mdd_props
